// file: inc/pdos_defines.svh
// Purpose: Offsets, field positions and reset values of the PWM output stage
// Assumes: Byte addresses on an 8-bit Wishbone address
// Notes: Generator g sits at PD_GBASE * (g + 1)
`ifndef PDOS_DEFINES_SVH
`define PDOS_DEFINES_SVH
`define PD_CTL     8'h00
`define PD_SYNC    8'h04
`define PD_OEN     8'h08
`define PD_INV     8'h0c
`define PD_FEN     8'h10
`define PD_FIEN    8'h14
`define PD_CLK     8'h24
`define PD_GBASE   8'h40
`define PD_GCTL    6'h00
`define PD_GSEL    6'h04
`define PD_GLOAD   6'h10
`define PD_GCNT    6'h14
`define PD_GCMPA   6'h18
`define PD_GCMPB   6'h1c
`define PD_GACTA   6'h20
`define PD_GACTB   6'h24
`define PD_GDB     6'h28
`define PD_GRISE   6'h2c
`define PD_GFALL   6'h30
`define PD_C_EN    0
`define PD_C_UD    1
`define PD_C_RUN   2
`define PD_C_SLD   3
`define PD_C_SCA   4
`define PD_C_SCB   5
`define PD_EV_Z    0
`define PD_EV_L    1
`define PD_EV_AU   2
`define PD_EV_AD   3
`define PD_EV_BU   4
`define PD_EV_BD   5
`define PD_TRG_LSB 8
`define PD_RST     32'h0000_0000
`define PD_DBMAX   12'hfff
`endif

// file: inc/pdos_pkg.sv
// Purpose: Types shared by the PWM output stage
// Assumes: Two generators, four pins
// Notes: Action codes follow the two-bit field encoding
package pdos_pkg;
	// Per-event action on a raw output
	typedef enum logic [1:0] {
		PDOS_NONE = 2'h0,
		PDOS_TOG  = 2'h1,
		PDOS_LOW  = 2'h2,
		PDOS_HIGH = 2'h3
	} pdos_act_t;
	// Bus slave states, one-hot
	typedef enum logic [1:0] {
		PDOS_IDLE = 2'b01,
		PDOS_ACK  = 2'b10
	} pdos_bus_t;
	// Load and compare set
	typedef struct packed {
		logic [15:0] load;
		logic [15:0] cmpa;
		logic [15:0] cmpb;
	} pdos_val_t;
	// Generator configuration
	typedef struct packed {
		logic [5:0]  ctl;
		logic [5:0]  int_sel;
		logic [5:0]  trg_sel;
		logic [11:0] act_a;
		logic [11:0] act_b;
		logic        db_en;
		logic [11:0] rise;
		logic [11:0] fall;
	} pdos_cfg_t;
endpackage

// file: logic/pdos_top.sv
// Purpose: Two PWM generators with dead band, events and pin control
// Assumes: Classic Wishbone slave, 40 MHz clk_i, sync reset
// Notes: Dead-band delays count clk_i cycles
// How it works
// - Dead band off: raw pair passes through
// - Dead band on: second raw signal dropped
// - First output: raw with delayed rising edge
// - Second output: inverted raw, delayed rise
// - Dead band on: pair never high together
// - Interrupt on any selected counter event
// - ADC trigger on separately selected events
// - Events use raw counter, not dead band
// - Global reset clears chosen counters together
// - Immediate update applies at next zero
// - Deferred update waits request, then zero
// - Update mode chosen per load and compare
// - Fault forces enabled outputs inactive
// - Fault can raise processor interrupt
// - Stall: keep running or stop at zero
// - Stall never raises an interrupt
// - Enable mask gates each pin drive
// - Optional per-pin inversion, default off
// - Down mode period is load plus one
// - Counting clock from divided system clock
// - Per event action: none, toggle, low, high
// - One-tick zero and load pulses
// - Update request self-clears, not by software
// - Counter reset request self-clears
`timescale 1ns/1ps
`include "pdos_defines.svh"
module pdos_top (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	input  wire logic        fault_i,
	input  wire logic        dbg_stall_i,
	output logic      [3:0]  pwm_o,
	output logic      [3:0]  pwm_oe_o,
	output logic      [1:0]  irq_o,
	output logic      [1:0]  adc_trig_o,
	output logic             fault_irq_o
);
	import pdos_pkg::*;

	// Byte-lane merge of a write
	function automatic logic [31:0] mrg(
		input logic [31:0] o,
		input logic [31:0] n,
		input logic [3:0]  s
	);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[8*i +: 8] = n[8*i +: 8];
			end
		end
		return r;
	endfunction

	// Apply one action code
	function automatic logic act(input logic c, input logic [1:0] a);
		logic r;
		r = c;
		unique case (pdos_act_t'(a))
			PDOS_NONE: r = c;
			PDOS_TOG:  r = ~c;
			PDOS_LOW:  r = 1'b0;
			PDOS_HIGH: r = 1'b1;
		endcase
		return r;
	endfunction

	// Step a raw output; own compare wins a coincidence
	function automatic logic step(
		input logic        c,
		input logic [5:0]  ev,
		input logic [11:0] a,
		input logic        is_b
	);
		logic r;
		logic own;
		r = c;
		own = is_b ? |ev[5:4] : |ev[3:2];
		if (ev[`PD_EV_Z]) r = act(r, a[1:0]);
		if (ev[`PD_EV_L]) r = act(r, a[3:2]);
		// Other comparator's actions count only while our own is silent
		if (!is_b || !own) begin
			if (ev[`PD_EV_AU]) r = act(r, a[5:4]);
			if (ev[`PD_EV_AD]) r = act(r, a[7:6]);
		end
		if (is_b || !own) begin
			if (ev[`PD_EV_BU]) r = act(r, a[9:8]);
			if (ev[`PD_EV_BD]) r = act(r, a[11:10]);
		end
		return r;
	endfunction

	// Divide-by-2^(code+1) terminal count
	function automatic logic [7:0] dmax(input logic [2:0] c);
		return 8'((9'h002 << c) - 9'h001);
	endfunction

	// Software-visible configuration
	pdos_bus_t   st;           // Bus state
	pdos_bus_t   next_st;
	pdos_cfg_t   cfg      [2]; // Generator setup
	pdos_cfg_t   next_cfg [2];
	pdos_val_t   sh       [2]; // Written values
	pdos_val_t   next_sh  [2];
	logic [3:0]  oen;          // Pin enable mask
	logic [3:0]  next_oen;
	logic [3:0]  inv;          // Pin inversion
	logic [3:0]  next_inv;
	logic [3:0]  fen;          // Fault enables
	logic [3:0]  next_fen;
	logic        fien;         // Fault interrupt enable
	logic        next_fien;
	logic [3:0]  ckc;          // Divider use and code
	logic [3:0]  next_ckc;
	logic [31:0] next_dat;
	// Write pulses toward the core
	logic [1:0]  wr_upd;
	logic [1:0]  wr_rst;
	logic [2:0]  wr_val   [2];

	// Core state
	pdos_val_t   cur      [2]; // Values in use
	pdos_val_t   next_cur [2];
	logic [2:0]  pend     [2]; // Waiting values
	logic [2:0]  next_pend[2];
	logic [15:0] cnt      [2];
	logic [15:0] next_cnt [2];
	logic [1:0]  dir;          // 1 counts up
	logic [1:0]  next_dir;
	logic [1:0]  upd;          // Deferred update request
	logic [1:0]  next_upd;
	logic [1:0]  rreq;         // Counter reset request
	logic [1:0]  next_rreq;
	logic [1:0]  ra;           // Raw first output
	logic [1:0]  next_ra;
	logic [1:0]  rb;           // Raw second output
	logic [1:0]  next_rb;
	logic [11:0] dca      [2]; // High-time counter
	logic [11:0] next_dca [2];
	logic [11:0] dcb      [2]; // Low-time counter
	logic [11:0] next_dcb [2];
	logic [3:0]  pout;         // Conditioned outputs
	logic [3:0]  next_pout;
	logic [1:0]  next_irq;
	logic [1:0]  next_trg;
	logic [7:0]  pre;          // Prescaler
	logic [7:0]  next_pre;
	logic        tick;
	logic [5:0]  ev       [2];
	logic [1:0]  run;
	logic [1:0]  zap;          // Apply at this zero

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Bus decode, register writes and read data
	always_comb begin
		logic        req;
		logic [31:0] w;
		logic [1:0]  g;
		req = cyc_i && stb_i && st == PDOS_IDLE;
		g = adr_i[7:6] - 2'd1;
		w = 32'h0000_0000;
		next_st = req ? PDOS_ACK : PDOS_IDLE;
		next_cfg = cfg;
		next_sh = sh;
		next_oen = oen;
		next_inv = inv;
		next_fen = fen;
		next_fien = fien;
		next_ckc = ckc;
		next_dat = dat_o;
		wr_upd = 2'b00;
		wr_rst = 2'b00;
		wr_val[0] = 3'b000;
		wr_val[1] = 3'b000;
		if (req) begin
			next_dat = `PD_RST; // Unmapped reads zero
			if (adr_i[7:6] == 2'd0) begin
				unique case (adr_i)
					`PD_CTL:  next_dat = {30'd0, upd};
					`PD_SYNC: next_dat = {30'd0, rreq};
					`PD_OEN:  next_dat = {28'd0, oen};
					`PD_INV:  next_dat = {28'd0, inv};
					`PD_FEN:  next_dat = {28'd0, fen};
					`PD_FIEN: next_dat = {31'd0, fien};
					`PD_CLK:  next_dat = {28'd0, ckc};
					default:  next_dat = `PD_RST;
				endcase
				w = mrg(next_dat, dat_i, sel_i);
				if (we_i) begin
					unique case (adr_i)
						`PD_CTL:  wr_upd = w[1:0];
						`PD_SYNC: wr_rst = w[1:0];
						`PD_OEN:  next_oen = w[3:0];
						`PD_INV:  next_inv = w[3:0];
						`PD_FEN:  next_fen = w[3:0];
						`PD_FIEN: next_fien = w[0];
						`PD_CLK:  next_ckc = w[3:0];
						default:  ;
					endcase
				end
			end else if (adr_i[7:6] != 2'd3) begin
				unique case (adr_i[5:0])
					`PD_GCTL:  next_dat = {26'd0, cfg[g[0]].ctl};
					`PD_GSEL:  next_dat = {18'd0, cfg[g[0]].trg_sel, 2'd0,
						cfg[g[0]].int_sel};
					`PD_GLOAD: next_dat = {16'd0, sh[g[0]].load};
					`PD_GCNT:  next_dat = {16'd0, cnt[g[0]]};
					`PD_GCMPA: next_dat = {16'd0, sh[g[0]].cmpa};
					`PD_GCMPB: next_dat = {16'd0, sh[g[0]].cmpb};
					`PD_GACTA: next_dat = {20'd0, cfg[g[0]].act_a};
					`PD_GACTB: next_dat = {20'd0, cfg[g[0]].act_b};
					`PD_GDB:   next_dat = {31'd0, cfg[g[0]].db_en};
					`PD_GRISE: next_dat = {20'd0, cfg[g[0]].rise};
					`PD_GFALL: next_dat = {20'd0, cfg[g[0]].fall};
					default:   next_dat = `PD_RST;
				endcase
				w = mrg(next_dat, dat_i, sel_i);
				if (we_i) begin
					unique case (adr_i[5:0])
						`PD_GCTL:  next_cfg[g[0]].ctl = w[5:0];
						`PD_GSEL: begin
							next_cfg[g[0]].int_sel = w[5:0];
							next_cfg[g[0]].trg_sel = w[13:8];
						end
						`PD_GLOAD: begin
							next_sh[g[0]].load = w[15:0];
							wr_val[g[0]] = 3'b001;
						end
						`PD_GCMPA: begin
							next_sh[g[0]].cmpa = w[15:0];
							wr_val[g[0]] = 3'b010;
						end
						`PD_GCMPB: begin
							next_sh[g[0]].cmpb = w[15:0];
							wr_val[g[0]] = 3'b100;
						end
						`PD_GACTA: next_cfg[g[0]].act_a = w[11:0];
						`PD_GACTB: next_cfg[g[0]].act_b = w[11:0];
						`PD_GDB:   next_cfg[g[0]].db_en = w[0];
						`PD_GRISE: next_cfg[g[0]].rise = w[11:0];
						`PD_GFALL: next_cfg[g[0]].fall = w[11:0];
						default:   ;
					endcase
				end
			end
		end
	end

	// Register file and bus state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= PDOS_IDLE;
			cfg[0] <= '0;
			cfg[1] <= '0;
			sh[0] <= '0;
			sh[1] <= '0;
			oen <= 4'h0;
			inv <= 4'h0;
			fen <= 4'h0;
			fien <= 1'b0;
			ckc <= 4'h0;
			dat_o <= `PD_RST;
		end else begin
			st <= next_st;
			cfg <= next_cfg;
			sh <= next_sh;
			oen <= next_oen;
			inv <= next_inv;
			fen <= next_fen;
			fien <= next_fien;
			ckc <= next_ckc;
			dat_o <= next_dat;
		end
	end

	// Ack rises the cycle after the request, falls the next
	assign ack_o = st == PDOS_ACK;

	// Counting clock tick from the system clock
	always_comb begin
		tick = !ckc[0] || pre == dmax(ckc[3:1]);
		next_pre = (tick || !ckc[0]) ? 8'h00 : pre + 8'h01;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) pre <= 8'h00;
		else pre <= next_pre;
	end

	// Counters, events, updates, raw outputs and dead band
	always_comb begin
		pdos_val_t e;
		logic      ma;
		logic      mb;
		logic      up;
		e = '0;
		ma = 1'b0;
		mb = 1'b0;
		up = 1'b0;
		next_cur = cur;
		next_pend = pend;
		next_cnt = cnt;
		next_dir = dir;
		next_ra = ra;
		next_rb = rb;
		next_dca = dca;
		next_dcb = dcb;
		next_upd = upd;
		next_rreq = wr_rst;
		for (int g = 0; g < 2; g++) begin
			up = cfg[g].ctl[`PD_C_UD] && dir[g];
			// Stall may hold at zero unless told to run on
			run[g] = cfg[g].ctl[`PD_C_EN] && tick && !rreq[g] &&
				!(dbg_stall_i && !cfg[g].ctl[`PD_C_RUN] && cnt[g] == 16'h0000);
			ev[g][`PD_EV_Z] = run[g] && cnt[g] == 16'h0000;
			ev[g][`PD_EV_L] = run[g] && cnt[g] == cur[g].load;
			ma = run[g] && cnt[g] == cur[g].cmpa && !(|ev[g][1:0]);
			mb = run[g] && cnt[g] == cur[g].cmpb && !(|ev[g][1:0]);
			ev[g][`PD_EV_AU] = ma && up;
			ev[g][`PD_EV_AD] = ma && !up;
			ev[g][`PD_EV_BU] = mb && up;
			ev[g][`PD_EV_BD] = mb && !up;
			// Deferred values also need the request
			zap[g] = ev[g][`PD_EV_Z];
			e = cur[g];
			if (zap[g]) begin
				if (pend[g][0] && (!cfg[g].ctl[`PD_C_SLD] || upd[g])) begin
					e.load = sh[g].load;
					next_pend[g][0] = 1'b0;
				end
				if (pend[g][1] && (!cfg[g].ctl[`PD_C_SCA] || upd[g])) begin
					e.cmpa = sh[g].cmpa;
					next_pend[g][1] = 1'b0;
				end
				if (pend[g][2] && (!cfg[g].ctl[`PD_C_SCB] || upd[g])) begin
					e.cmpb = sh[g].cmpb;
					next_pend[g][2] = 1'b0;
				end
				next_upd[g] = 1'b0;
			end
			next_cur[g] = e;
			next_pend[g] = next_pend[g] | wr_val[g];
			next_upd[g] = next_upd[g] | wr_upd[g];
			if (rreq[g]) begin
				next_cnt[g] = 16'h0000;
				next_dir[g] = 1'b1;
			end else if (run[g]) begin
				if (!cfg[g].ctl[`PD_C_UD]) begin
					next_dir[g] = 1'b0;
					next_cnt[g] = (cnt[g] == 16'h0000) ? e.load : cnt[g] - 16'h0001;
				end else begin
					if (cnt[g] == 16'h0000) next_dir[g] = 1'b1;
					else if (cnt[g] >= e.load) next_dir[g] = 1'b0;
					next_cnt[g] = next_dir[g] ? cnt[g] + 16'h0001 : cnt[g] - 16'h0001;
					if (e.load == 16'h0000) next_cnt[g] = 16'h0000;
				end
			end
			next_ra[g] = step(ra[g], ev[g], cfg[g].act_a, 1'b0);
			next_rb[g] = step(rb[g], ev[g], cfg[g].act_b, 1'b1);
			next_dca[g] = !ra[g] ? 12'h000 : (dca[g] == `PD_DBMAX ? dca[g] : dca[g] + 12'h001);
			next_dcb[g] = ra[g] ? 12'h000 : (dcb[g] == `PD_DBMAX ? dcb[g] : dcb[g] + 12'h001);
			if (!cfg[g].db_en) begin
				next_pout[2*g] = ra[g];
				next_pout[2*g+1] = rb[g];
			end else begin
				// Both low only while a delay runs
				next_pout[2*g] = ra[g] && dca[g] >= cfg[g].rise;
				next_pout[2*g+1] = !ra[g] && dcb[g] >= cfg[g].fall;
			end
			// Raw events only; stall adds no source
			next_irq[g] = |(ev[g] & cfg[g].int_sel);
			next_trg[g] = |(ev[g] & cfg[g].trg_sel);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int g = 0; g < 2; g++) begin
				cur[g] <= '0;
				pend[g] <= 3'b000;
				cnt[g] <= 16'h0000;
				dca[g] <= 12'h000;
				dcb[g] <= 12'h000;
			end
			dir <= 2'b00;
			upd <= 2'b00;
			rreq <= 2'b00;
			ra <= 2'b00;
			rb <= 2'b00;
			pout <= 4'h0;
			irq_o <= 2'b00;
			adc_trig_o <= 2'b00;
		end else begin
			cur <= next_cur;
			pend <= next_pend;
			cnt <= next_cnt;
			dca <= next_dca;
			dcb <= next_dcb;
			dir <= next_dir;
			upd <= next_upd;
			rreq <= next_rreq;
			ra <= next_ra;
			rb <= next_rb;
			pout <= next_pout;
			irq_o <= next_irq;
			adc_trig_o <= next_trg;
		end
	end

	// Pins: fault acts at once, without waiting for a tick
	assign pwm_o = ((fault_i ? ~fen : 4'hf) & pout) ^ inv;
	assign pwm_oe_o = oen;
	assign fault_irq_o = fault_i && fien;

	// Checks
	sequence s_zero_wait;
		upd[0] && !zap[0] ##1 zap[0];
	endsequence

	property p_bypass;
		!cfg[0].db_en ##1 !cfg[0].db_en |-> pout[1:0] == $past({rb[0], ra[0]});
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass mismatch");

	property p_never_both;
		$past(cfg[0].db_en) |-> !(pout[0] && pout[1]);
	endproperty
	a_never_both: assert property (p_never_both) else $error("pair overlap");

	property p_rise_delay;
		$rose(pout[0]) && $past(cfg[0].db_en) |-> $past(dca[0]) >= $past(cfg[0].rise);
	endproperty
	a_rise_delay: assert property (p_rise_delay) else $error("rise early");

	property p_countdown;
		run[0] && !cfg[0].ctl[`PD_C_UD] && cnt[0] != 16'h0000 |=> cnt[0] == $past(cnt[0]) - 16'h0001;
	endproperty
	a_countdown: assert property (p_countdown) else $error("count step");

	property p_sync_rst;
		rreq[0] |=> cnt[0] == 16'h0000 && cnt[1] == ($past(rreq[1]) ? 16'h0000 : cnt[1]);
	endproperty
	a_sync_rst: assert property (p_sync_rst) else $error("reset missed");

	property p_upd_clear;
		s_zero_wait ##0 !wr_upd[0] |=> !upd[0];
	endproperty
	a_upd_clear: assert property (p_upd_clear) else $error("request stuck");

	property p_immediate;
		zap[0] && pend[0][0] && !cfg[0].ctl[`PD_C_SLD] |=> cur[0].load == $past(sh[0].load);
	endproperty
	a_immediate: assert property (p_immediate) else $error("no update");

	property p_deferred;
		zap[0] && pend[0][0] && cfg[0].ctl[`PD_C_SLD] && !upd[0] |=> $stable(cur[0].load);
	endproperty
	a_deferred: assert property (p_deferred) else $error("early update");

	property p_fault;
		fault_i && fen[0] |-> pwm_o[0] == inv[0];
	endproperty
	a_fault: assert property (p_fault) else $error("fault not forced");

	property p_irq;
		|(ev[0] & cfg[0].int_sel) |=> irq_o[0];
	endproperty
	a_irq: assert property (p_irq) else $error("irq missing");
endmodule

// file: verification/pdos_bridge.sv
// Purpose: Half-bridge power stage model on one generator pin pair
// Assumes: High-side switch on the first pin, low-side on the second
// Notes: Counts shoot-through cycles for the bench to read back
`timescale 1ns/1ps
module pdos_bridge (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [1:0]  pwm_i,
	input  wire logic [1:0]  oe_i,
	output logic      [15:0] shoot_o
);
	logic [1:0] gate; // Gate level each switch sees
	// Released pin sits at its pull-down, so that switch is off
	assign gate = pwm_i & oe_i;
	// Both switches on means the rail is shorted
	always @(posedge clk_i) begin
		if (rst_i) begin
			shoot_o <= 16'h0000;
		end else if (gate === 2'b11) begin
			shoot_o <= shoot_o + 16'h0001;
		end
	end
endmodule

// file: verification/tb_top.sv
// Purpose: Self-checking bench of the PWM output stage
// Assumes: 40 MHz clk_i, divider off unless a scenario sets it
// Notes: Periods and widths are counted in clk_i cycles at rising edges
`timescale 1ns/1ps
module tb_top;
	import pdos_pkg::*;
	logic        clk_i, rst_i, cyc_i, stb_i, we_i, fault_i, dbg_stall_i;
	logic [7:0]  adr_i;     // Byte address
	logic [3:0]  sel_i;     // All lanes, every access is a full word
	logic [31:0] dat_i, dat_o, d;
	logic        ack_o, fault_irq_o;
	logic [3:0]  pwm_o, pwm_oe_o, v, fm;
	logic [1:0]  irq_o, adc_trig_o;
	logic [15:0] shoot;     // Shoot-through cycles seen by the bridge
	int          n_fail, checked, L, C, C2, r, f, a, b, g1, g2, p, k;
	// Free-running system clock
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	pdos_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
		.ack_o(ack_o), .fault_i(fault_i), .dbg_stall_i(dbg_stall_i), .pwm_o(pwm_o),
		.pwm_oe_o(pwm_oe_o), .irq_o(irq_o), .adc_trig_o(adc_trig_o),
		.fault_irq_o(fault_irq_o));
	pdos_bridge u_bridge (.clk_i(clk_i), .rst_i(rst_i), .pwm_i(pwm_o[1:0]),
		.oe_i(pwm_oe_o[1:0]), .shoot_o(shoot));
	// Verdict and end of run
	task automatic results();
		$display("Checks %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One classic cycle; no latency assumed, the watchdog bounds a hang
	task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		sel_i <= 4'hf;
		adr_i <= ad;
		dat_i <= wd;
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] ad, input int wd);
		wb(1'b1, ad, wd, d);
	endtask
	// Cycles until the next irq or trigger pulse of a generator
	task automatic evw(input int g, input int tr, output int n);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while ((tr ? adc_trig_o[g] : irq_o[g]) !== 1'b1 && n < 3000);
	endtask
	task automatic per(input int g, output int n);
		evw(g, 0, n);
		evw(g, 0, n);
	endtask
	// Cycles until a pin shows the given level
	task automatic cnt(input int bt, input logic lv, output int n);
		n = 0;
		while (pwm_o[bt] !== lv && n < 3000) begin
			@(posedge clk_i);
			n++;
		end
	endtask
	// Zero event on irq, load event one tick later on trigger
	task automatic ev0(input int e);
		per(0, p);
		chk(p, e);
		@(posedge clk_i);
		chk({irq_o[0], adc_trig_o[0]}, 2'b01);
		@(posedge clk_i);
		chk(adc_trig_o[0], 1'b0);
	endtask
	function automatic int eper(input int l, input int ud, input int dv);
		return ud ? 2 * l * dv : (l + 1) * dv;
	endfunction
	// Set high at zero, cleared at the down match
	function automatic int ehi(input int l, input int c);
		return l - c + 1;
	endfunction
	// Hang guard, far beyond the expected run
	initial begin
		#1_000_000;
		n_fail++;
		results();
	end
	initial begin
		{cyc_i, stb_i, we_i, fault_i, dbg_stall_i} = 5'h00;
		adr_i = 8'h00;
		dat_i = 32'h0000_0000;
		sel_i = 4'hf;
		rst_i = 1'b1;
		n_fail = 0;
		checked = 0;
		void'($urandom(79804));
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk({pwm_oe_o, pwm_o}, 8'h00);
		wb(1'b0, 8'h08, 0, d);
		chk(d, 32'h0000_0000);
		wr(8'hfc, 32'hffff_ffff);
		wb(1'b0, 8'hfc, 0, d);
		chk(d, 32'h0000_0000);
		// Down mode, raw pair straight through
		L  = 12 + $urandom % 16;
		C  = 6 + $urandom % (L - 10);
		C2 = 6 + $urandom % (L - 10);
		wr(8'h50, L);
		wr(8'h58, C);
		wr(8'h5c, C2);
		wr(8'h60, 32'h0000_0083);
		wr(8'h64, 32'h0000_0803);
		wr(8'h44, 32'h0000_0201);
		wr(8'h40, 32'h0000_0001);
		wr(8'h08, 32'h0000_0003);
		chk(pwm_oe_o, 4'h3);
		ev0(eper(L, 0, 1));
		cnt(0, 0, a);
		cnt(0, 1, a);
		cnt(0, 0, a);
		chk(a, ehi(L, C));
		cnt(1, 0, b);
		cnt(1, 1, b);
		cnt(1, 0, b);
		chk(b, ehi(L, C2));
		// Dead band: pair built from the first raw signal only
		r = 1 + $urandom % 3;
		f = 1 + $urandom % 3;
		wr(8'h6c, r);
		wr(8'h70, f);
		wr(8'h68, 1);
		ev0(eper(L, 0, 1));
		ev0(eper(L, 0, 1));
		// Snapshot only once the pass-through overlap has drained
		k = shoot;
		cnt(0, 0, a);
		cnt(0, 1, a);
		cnt(0, 0, a);
		cnt(1, 1, g1);
		cnt(1, 0, b);
		cnt(0, 1, g2);
		chk(a + g1 + b + g2, L + 1);
		chk(g1 - g2, f - r);
		chk(g1 > 0 && g2 > 0, 1);
		chk(shoot, k);
		// Fault forcing must land without a clock edge
		v  = 4'($urandom);
		fm = 4'($urandom);
		wr(8'h0c, v);
		wr(8'h10, fm);
		wr(8'h14, 1);
		@(posedge clk_i);
		fault_i <= 1'b1;
		#1;
		chk((pwm_o ^ v) & (fm | 4'hc), 4'h0);
		chk(fault_irq_o, 1'b1);
		@(posedge clk_i);
		fault_i <= 1'b0;
		#1;
		chk(fault_irq_o, 1'b0);
		wr(8'h0c, 0);
		wr(8'h10, 0);
		// Both counters cleared in one cycle
		wr(8'h90, L);
		wr(8'ha0, 32'h0000_0083);
		wr(8'h84, 1);
		wr(8'h80, 1);
		wr(8'h04, 3);
		wb(1'b0, 8'h04, 0, d);
		chk(d, 32'h0000_0000);
		evw(0, 0, k);
		chk(irq_o, 2'b11);
		// Deferred load on one block, immediate on the other
		wr(8'h40, 32'h0000_0009);
		wr(8'h50, L + 3);
		wr(8'h90, L + 3);
		repeat (3) per(0, p);
		chk(p, eper(L, 0, 1));
		per(1, p);
		chk(p, eper(L + 3, 0, 1));
		wr(8'h00, 1);
		repeat (2) per(0, p);
		chk(p, eper(L + 3, 0, 1));
		wb(1'b0, 8'h00, 0, d);
		chk(d, 32'h0000_0000);
		// Counting clock divider codes
		for (k = 0; k < 3; k++) begin
			wr(8'h24, 1 + 2 * k);
			repeat (2) per(0, p);
			chk(p, eper(L + 3, 0, 2 << k));
		end
		wr(8'h24, 0);
		// Up/down, each of the six events alone
		wr(8'h40, 32'h0000_0003);
		for (k = 0; k < 6; k++) begin
			wr(8'h44, 1 << k);
			repeat (2) per(0, p);
			chk(p, eper(L + 3, 1, 1));
		end
		// Toggle on zero: raw high a full cycle, rise still delayed
		wr(8'h60, 1);
		cnt(0, 0, a);
		cnt(0, 1, a);
		cnt(0, 0, a);
		chk(a, eper(L + 3, 1, 1) - r);
		// Stall: stop at zero, then keep running
		wr(8'h40, 1);
		wr(8'h44, 1);
		dbg_stall_i <= 1'b1;
		repeat (2 * (L + 4)) @(posedge clk_i);
		evw(0, 0, p);
		chk(p, 3000);
		chk({irq_o, fault_irq_o}, 3'h0);
		wr(8'h40, 5);
		repeat (2) per(0, p);
		chk(p, eper(L + 3, 0, 1));
		dbg_stall_i <= 1'b0;
		results();
	end
endmodule
